// ===== verilog/plc_line_control.sv
// Purpose: per-line control and status of a 32-line parallel I/O controller
// Assumes: single 125 MHz clock, asynchronous active-high reset, plain register port
// Notes: pins are synchronised, optionally glitch filtered, then watched for change
//
// Notes on behaviour
// - bit n of every per-line register belongs to line n, 0 to 31
// - output status reads 1 where the line's driver is enabled, else 0
// - writing 1 to filter enable turns the line's glitch filter on
// - writing 1 to filter disable turns the line's glitch filter off
// - filter status reads 1 for lines whose glitch filter is on
// - writing 1 to drive set makes the line's drive value high
// - writing 1 to drive clear makes the line's drive value low
// - drive state reads the value currently scheduled for each line
// - drive state is always readable and may also be written directly
// - direct drive writes act only on lines with write permission set
// - pin level sample reads the sampled pin level, regardless of outputs
// - pins are sampled only on clock edges; stopped clock holds last levels
// - writing 1 to change irq enable arms that line's change interrupt
// - writing 1 to change irq disable disarms that line's change interrupt
// - change irq mask reads 1 for every armed line
// - change status sets on a detected level change, clears on read or reset
// - change status resets to zero; events after reset may show at once
// - writing 1 to open drain enable makes the line open-drain
// - writing 1 to open drain disable returns the line to push-pull
// - open-drain lines drive low only; status reads the mode per line
// - writing 1 to pull-up disable switches off that line's pull-up
`timescale 1ns/1ns

module plc_line_control #(
    parameter int LINES = plc_pkg::LINES,
    parameter int FILTER_CYCLES = plc_pkg::FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [plc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [plc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [plc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [LINES-1:0] line_in,
    output logic [LINES-1:0] line_out,
    output logic [LINES-1:0] line_oe_n,
    output logic [LINES-1:0] line_pullup_en,
    output logic irq
);

    localparam logic [plc_pkg::FILTER_CNT_W-1:0] FILT_LAST =
        plc_pkg::FILTER_CNT_W'(FILTER_CYCLES - 1);

    logic [LINES-1:0] in_meta;
    logic [LINES-1:0] in_sync;
    logic [LINES-1:0] pin_level;
    logic [LINES-1:0] level_prev;
    logic [LINES-1:0] change_evt;
    logic [LINES-1:0] out_enabled;
    logic [LINES-1:0] filter_on;
    logic [LINES-1:0] drive_state;
    logic [LINES-1:0] write_permit;
    logic [LINES-1:0] irq_mask;
    logic [LINES-1:0] change_status;
    logic [LINES-1:0] open_drain;
    logic [LINES-1:0] wbits;
    logic [plc_pkg::DATA_W-1:0] next_rdata;

    // write decode, one strobe per register
    logic wr_oe_en;
    logic wr_oe_dis;
    logic wr_filt_en;
    logic wr_filt_dis;
    logic wr_set;
    logic wr_clr;
    logic wr_state;
    logic wr_irq_en;
    logic wr_irq_dis;
    logic wr_od_en;
    logic wr_od_dis;
    logic wr_pu_dis;
    logic wr_pu_en;
    logic wr_perm_en;
    logic wr_perm_dis;
    logic rd_status;

    assign wbits = reg_wdata[LINES-1:0];
    assign wr_oe_en = reg_wr && (reg_addr == plc_pkg::OFF_OUT_ENABLE);
    assign wr_oe_dis = reg_wr && (reg_addr == plc_pkg::OFF_OUT_DISABLE);
    assign wr_filt_en = reg_wr && (reg_addr == plc_pkg::OFF_GLITCH_FILTER_ENABLE);
    assign wr_filt_dis = reg_wr && (reg_addr == plc_pkg::OFF_GLITCH_FILTER_DISABLE);
    assign wr_set = reg_wr && (reg_addr == plc_pkg::OFF_DRIVE_VALUE_SET);
    assign wr_clr = reg_wr && (reg_addr == plc_pkg::OFF_DRIVE_VALUE_CLEAR);
    assign wr_state = reg_wr && (reg_addr == plc_pkg::OFF_DRIVE_VALUE_STATE);
    assign wr_irq_en = reg_wr && (reg_addr == plc_pkg::OFF_CHANGE_IRQ_ENABLE);
    assign wr_irq_dis = reg_wr && (reg_addr == plc_pkg::OFF_CHANGE_IRQ_DISABLE);
    assign wr_od_en = reg_wr && (reg_addr == plc_pkg::OFF_OPEN_DRAIN_ENABLE);
    assign wr_od_dis = reg_wr && (reg_addr == plc_pkg::OFF_OPEN_DRAIN_DISABLE);
    assign wr_pu_dis = reg_wr && (reg_addr == plc_pkg::OFF_PULLUP_DISABLE);
    assign wr_pu_en = reg_wr && (reg_addr == plc_pkg::OFF_PULLUP_ENABLE);
    assign wr_perm_en = reg_wr && (reg_addr == plc_pkg::OFF_WRITE_PERMIT_ENABLE);
    assign wr_perm_dis = reg_wr && (reg_addr == plc_pkg::OFF_WRITE_PERMIT_DISABLE);
    assign rd_status = reg_rd && (reg_addr == plc_pkg::OFF_CHANGE_EVENT_STATUS);

    // pin synchroniser; in_meta feeds in_sync only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= line_in;
            in_sync <= in_meta;
        end
    end

    // per-line glitch filter: a new level must persist before it is taken
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            logic [plc_pkg::FILTER_CNT_W-1:0] hold_cnt;
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    hold_cnt <= '0;
                    pin_level[gi] <= 1'b0;
                end else if (!filter_on[gi] || in_sync[gi] == pin_level[gi]) begin
                    hold_cnt <= '0;
                    pin_level[gi] <= in_sync[gi];
                end else if (hold_cnt == FILT_LAST) begin
                    hold_cnt <= '0;
                    pin_level[gi] <= in_sync[gi];
                end else begin
                    hold_cnt <= hold_cnt + plc_pkg::FILTER_CNT_W'(1);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_prev <= '0;
        end else begin
            level_prev <= pin_level;
        end
    end

    // any edge counts, rising or falling
    assign change_evt = pin_level ^ level_prev;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_enabled <= plc_pkg::RST_ALL_CLEAR;
        end else if (wr_oe_en) begin
            out_enabled <= out_enabled | wbits;
        end else if (wr_oe_dis) begin
            out_enabled <= out_enabled & ~wbits;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            filter_on <= plc_pkg::RST_ALL_CLEAR;
        end else if (wr_filt_en) begin
            filter_on <= filter_on | wbits;
        end else if (wr_filt_dis) begin
            filter_on <= filter_on & ~wbits;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            drive_state <= plc_pkg::RST_ALL_CLEAR;
        end else if (wr_set) begin
            drive_state <= drive_state | wbits;
        end else if (wr_clr) begin
            drive_state <= drive_state & ~wbits;
        end else if (wr_state) begin
            // lines without permission keep their value
            drive_state <= (drive_state & ~write_permit) | (wbits & write_permit);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            write_permit <= plc_pkg::RST_ALL_CLEAR;
        end else if (wr_perm_en) begin
            write_permit <= write_permit | wbits;
        end else if (wr_perm_dis) begin
            write_permit <= write_permit & ~wbits;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask <= plc_pkg::RST_ALL_CLEAR;
        end else if (wr_irq_en) begin
            irq_mask <= irq_mask | wbits;
        end else if (wr_irq_dis) begin
            irq_mask <= irq_mask & ~wbits;
        end
    end

    // read clears, but an event in the reading cycle survives
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            change_status <= plc_pkg::RST_ALL_CLEAR;
        end else if (rd_status) begin
            change_status <= change_evt;
        end else begin
            change_status <= change_status | change_evt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            open_drain <= plc_pkg::RST_ALL_CLEAR;
        end else if (wr_od_en) begin
            open_drain <= open_drain | wbits;
        end else if (wr_od_dis) begin
            open_drain <= open_drain & ~wbits;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_pullup_en <= plc_pkg::RST_PULLUP_ON[LINES-1:0];
        end else if (wr_pu_dis) begin
            line_pullup_en <= line_pullup_en & ~wbits;
        end else if (wr_pu_en) begin
            line_pullup_en <= line_pullup_en | wbits;
        end
    end

    // pad drive registered; open-drain lines release instead of driving high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_out <= '0;
            line_oe_n <= '1;
        end else begin
            line_out <= drive_state & ~open_drain;
            line_oe_n <= ~(out_enabled & ~(open_drain & drive_state));
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(change_status & irq_mask);
        end
    end

    always_comb begin
        next_rdata = plc_pkg::READ_UNMAPPED;
        case (reg_addr)
            plc_pkg::OFF_OUTPUT_ENABLED_STATUS: next_rdata[LINES-1:0] = out_enabled;
            plc_pkg::OFF_GLITCH_FILTER_STATUS: next_rdata[LINES-1:0] = filter_on;
            plc_pkg::OFF_DRIVE_VALUE_STATE: next_rdata[LINES-1:0] = drive_state;
            plc_pkg::OFF_PIN_LEVEL_SAMPLE: next_rdata[LINES-1:0] = pin_level;
            plc_pkg::OFF_CHANGE_IRQ_MASK: next_rdata[LINES-1:0] = irq_mask;
            plc_pkg::OFF_CHANGE_EVENT_STATUS: next_rdata[LINES-1:0] = change_status;
            plc_pkg::OFF_OPEN_DRAIN_STATUS: next_rdata[LINES-1:0] = open_drain;
            plc_pkg::OFF_PULLUP_STATUS: next_rdata[LINES-1:0] = ~line_pullup_en;
            plc_pkg::OFF_DIRECT_WRITE_PERMISSION_STATUS: next_rdata[LINES-1:0] = write_permit;
            default: next_rdata = plc_pkg::READ_UNMAPPED;
        endcase
    end

    // data holds only in the cycle after the read strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= plc_pkg::READ_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= plc_pkg::READ_UNMAPPED;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_write(logic [7:0] off);
        reg_wr && reg_addr == off;
    endsequence

    sequence s_read(logic [7:0] off);
        reg_rd && reg_addr == off;
    endsequence

    property p_set_drive;
        s_write(plc_pkg::OFF_DRIVE_VALUE_SET) |=>
            ((drive_state & $past(wbits)) == $past(wbits)) &&
            ((drive_state & ~$past(wbits)) == ($past(drive_state) & ~$past(wbits)));
    endproperty
    a_set_drive: assert property (p_set_drive) else $error("drive set failed");

    property p_clear_drive;
        s_write(plc_pkg::OFF_DRIVE_VALUE_CLEAR) |=>
            ((drive_state & $past(wbits)) == '0) &&
            ((drive_state & ~$past(wbits)) == ($past(drive_state) & ~$past(wbits)));
    endproperty
    a_clear_drive: assert property (p_clear_drive) else $error("drive clear failed");

    property p_direct_write;
        s_write(plc_pkg::OFF_DRIVE_VALUE_STATE) |=>
            drive_state == (($past(drive_state) & ~$past(write_permit)) |
                            ($past(wbits) & $past(write_permit)));
    endproperty
    a_direct_write: assert property (p_direct_write) else $error("gated write wrong");

    // an idle cycle between write and read, so no disable can slip in
    property p_filter_toggle;
        s_write(plc_pkg::OFF_GLITCH_FILTER_ENABLE) ##1 !reg_wr ##1
            s_read(plc_pkg::OFF_GLITCH_FILTER_STATUS) |=>
            (reg_rdata[LINES-1:0] & $past(wbits, 3)) == $past(wbits, 3);
    endproperty
    a_filter_toggle: assert property (p_filter_toggle) else $error("filter status");

    property p_filter_off;
        s_write(plc_pkg::OFF_GLITCH_FILTER_DISABLE) |=> (filter_on & $past(wbits)) == '0;
    endproperty
    a_filter_off: assert property (p_filter_off) else $error("filter not off");

    property p_status_read;
        s_read(plc_pkg::OFF_CHANGE_EVENT_STATUS) |=>
            reg_rdata[LINES-1:0] == $past(change_status) && change_status == $past(change_evt);
    endproperty
    a_status_read: assert property (p_status_read) else $error("read-clear wrong");

    property p_event_kept;
        (|change_evt) |=> (change_status & $past(change_evt)) == $past(change_evt);
    endproperty
    a_event_kept: assert property (p_event_kept) else $error("change event lost");

    property p_irq_cause;
        (|(change_evt & irq_mask)) && !reg_wr |=> ##1 irq;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq missing");

    property p_no_high_drive;
        (($past(open_drain) & line_out) == '0) &&
            (($past(out_enabled & open_drain & ~drive_state) & line_oe_n) == '0);
    endproperty
    a_no_high_drive: assert property (p_no_high_drive) else $error("open drain high");

    property p_mask_arm;
        s_write(plc_pkg::OFF_CHANGE_IRQ_ENABLE) ##1 !reg_wr ##1
            s_read(plc_pkg::OFF_CHANGE_IRQ_MASK) |=>
            (reg_rdata[LINES-1:0] & $past(wbits, 3)) == $past(wbits, 3);
    endproperty
    a_mask_arm: assert property (p_mask_arm) else $error("mask not armed");

    property p_unmapped;
        reg_rd && reg_addr == 8'h1C |=> reg_rdata == plc_pkg::READ_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_filter_on;
        s_write(plc_pkg::OFF_GLITCH_FILTER_ENABLE) |=>
            (filter_on & $past(wbits)) == $past(wbits);
    endproperty
    a_filter_on: assert property (p_filter_on) else $error("filter not on");

    property p_od_on;
        s_write(plc_pkg::OFF_OPEN_DRAIN_ENABLE) |=>
            (open_drain & $past(wbits)) == $past(wbits);
    endproperty
    a_od_on: assert property (p_od_on) else $error("open drain not on");

    property p_od_off;
        s_write(plc_pkg::OFF_OPEN_DRAIN_DISABLE) |=>
            (open_drain & $past(wbits)) == '0;
    endproperty
    a_od_off: assert property (p_od_off) else $error("open drain not off");

    property p_pullup_off;
        s_write(plc_pkg::OFF_PULLUP_DISABLE) |=>
            (line_pullup_en & $past(wbits)) == '0;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up still on");

    property p_mask_off;
        s_write(plc_pkg::OFF_CHANGE_IRQ_DISABLE) |=>
            (irq_mask & $past(wbits)) == '0;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("mask not disarmed");

endmodule : plc_line_control

// ===== verilog/plc_pkg.sv
// Purpose: shared constants for the 32-line parallel line controller
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes: one bit per line in every per-line register
package plc_pkg;

    localparam int LINES = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_OUT_ENABLE = 8'h10;
    localparam logic [7:0] OFF_OUT_DISABLE = 8'h14;
    localparam logic [7:0] OFF_OUTPUT_ENABLED_STATUS = 8'h18;
    localparam logic [7:0] OFF_GLITCH_FILTER_ENABLE = 8'h20;
    localparam logic [7:0] OFF_GLITCH_FILTER_DISABLE = 8'h24;
    localparam logic [7:0] OFF_GLITCH_FILTER_STATUS = 8'h28;
    localparam logic [7:0] OFF_DRIVE_VALUE_SET = 8'h30;
    localparam logic [7:0] OFF_DRIVE_VALUE_CLEAR = 8'h34;
    localparam logic [7:0] OFF_DRIVE_VALUE_STATE = 8'h38;
    localparam logic [7:0] OFF_PIN_LEVEL_SAMPLE = 8'h3C;
    localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h40;
    localparam logic [7:0] OFF_CHANGE_IRQ_DISABLE = 8'h44;
    localparam logic [7:0] OFF_CHANGE_IRQ_MASK = 8'h48;
    localparam logic [7:0] OFF_CHANGE_EVENT_STATUS = 8'h4C;
    localparam logic [7:0] OFF_OPEN_DRAIN_ENABLE = 8'h50;
    localparam logic [7:0] OFF_OPEN_DRAIN_DISABLE = 8'h54;
    localparam logic [7:0] OFF_OPEN_DRAIN_STATUS = 8'h58;
    localparam logic [7:0] OFF_PULLUP_DISABLE = 8'h60;
    localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h64;
    localparam logic [7:0] OFF_PULLUP_STATUS = 8'h68;
    localparam logic [7:0] OFF_WRITE_PERMIT_ENABLE = 8'hA0;
    localparam logic [7:0] OFF_WRITE_PERMIT_DISABLE = 8'hA4;
    localparam logic [7:0] OFF_DIRECT_WRITE_PERMISSION_STATUS = 8'hA8;

    // reset values
    localparam logic [31:0] RST_ALL_CLEAR = 32'h0000_0000;
    localparam logic [31:0] RST_PULLUP_ON = 32'hFFFF_FFFF;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // glitch filter: cycles a new level must persist before it is accepted
    localparam int FILTER_CYCLES = 2;
    localparam int FILTER_CNT_W = 2;

endpackage : plc_pkg

// ===== dv/plc_pad_model.sv
// Purpose: pad model joining the controller's drive, pull-ups and outside drivers
// Assumes: bench drives ext_en/ext_val for lines driven from outside the chip
// Notes: a floating line toggles every cycle so a stale level is never read
`timescale 1ns/1ns

module plc_pad_model (
    input wire logic clk,
    input wire logic [31:0] line_out,
    input wire logic [31:0] line_oe_n,
    input wire logic [31:0] line_pullup_en,
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    output logic [31:0] line_in
);
    logic float_pat = 1'b0;

    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    // the device's drive wins, then outside drivers, then the pull-up
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!line_oe_n[i]) begin
                line_in[i] = line_out[i];
            end else if (ext_en[i]) begin
                line_in[i] = ext_val[i];
            end else if (line_pullup_en[i]) begin
                line_in[i] = 1'b1;
            end else begin
                line_in[i] = float_pat ^ i[0];
            end
        end
    end
endmodule : plc_pad_model

// ===== dv/plc_line_control_tb.sv
// Purpose: register-level test of the parallel line controller
// Assumes: read data stands only in the cycle after the read strobe
// Notes: pin latency waits are generous fixed spans after pin changes
`timescale 1ns/1ns

module plc_line_control_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] line_in;
    logic [31:0] line_out;
    logic [31:0] line_oe_n;
    logic [31:0] line_pullup_en;
    logic [31:0] ext_en = 32'h0000_0000;
    logic [31:0] ext_val = 32'h0000_0000;
    logic irq;
    int miscompares = 0;
    int checks = 0;
    logic [7:0] zero_regs [8] = '{8'h18, 8'h28, 8'h38, 8'h48, 8'h58, 8'h68, 8'hA8, 8'h1C};

    always #4 clk = ~clk;

    plc_line_control #(.LINES(32), .FILTER_CYCLES(2)) dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in),
        .line_out(line_out), .line_oe_n(line_oe_n), .line_pullup_en(line_pullup_en),
        .irq(irq)
    );

    plc_pad_model pads (
        .clk(clk), .line_out(line_out), .line_oe_n(line_oe_n),
        .line_pullup_en(line_pullup_en), .ext_en(ext_en), .ext_val(ext_val),
        .line_in(line_in)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd_chk

    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (zero_regs[i]) rd_chk("reset value", zero_regs[i], 32'h0000_0000);
        chk("pull-ups after reset", 32'hFFFF_FFFF, line_pullup_en);
        $display("test reset done");
        // output status and set/clear, bit 31 and bit 0 for line order
        wr_reg(8'h10, 32'h0000_00FF);
        rd_chk("output status", 8'h18, 32'h0000_00FF);
        wr_reg(8'h30, 32'h8000_0005);
        rd_chk("drive after set", 8'h38, 32'h8000_0005);
        wr_reg(8'h34, 32'h0000_0001);
        rd_chk("drive after clear", 8'h38, 32'h8000_0004);
        chk("line_out", 32'h8000_0004, line_out);
        wr_reg(8'h38, 32'h0000_0003);
        rd_chk("drive write refused", 8'h38, 32'h8000_0004);
        wr_reg(8'hA0, 32'h0000_000F);
        wr_reg(8'h38, 32'hFFFF_0003);
        rd_chk("drive write permitted", 8'h38, 32'h8000_0003);
        wr_reg(8'hA4, 32'h0000_0001);
        rd_chk("write permission", 8'hA8, 32'h0000_000E);
        $display("test drive done");
        wr_reg(8'h20, 32'h0000_0C00);
        rd_chk("filter enabled", 8'h28, 32'h0000_0C00);
        wr_reg(8'h24, 32'h0000_0800);
        rd_chk("filter status", 8'h28, 32'h0000_0400);
        wr_reg(8'h50, 32'h0000_0003);
        wr_reg(8'h54, 32'h0000_0002);
        rd_chk("open-drain status", 8'h58, 32'h0000_0001);
        @(posedge clk);
        // line 0 open-drain driving high is released, line 1 push-pull drives
        chk("open-drain pads oe", 32'h0000_0001, {30'h0, line_oe_n[1:0]});
        chk("open-drain pads out", 32'h0000_0002, {30'h0, line_out[1:0]});
        wr_reg(8'h60, 32'hFFFF_0000);
        rd_chk("pull-up status", 8'h68, 32'hFFFF_0000);
        @(posedge clk);
        chk("pull-up pads", 32'h0000_FFFF, line_pullup_en);
        wr_reg(8'h64, 32'h0001_0000);
        rd_chk("pull-up restored", 8'h68, 32'hFFFE_0000);
        $display("test pad modes done");
        @(posedge clk);
        ext_en <= 32'hFFFF_FF00;
        ext_val <= 32'hA5A5_5A00;
        repeat (10) @(posedge clk);
        rd_chk("pin levels", 8'h3C, 32'hA5A5_5A03);
        repeat (4) @(posedge clk);
        // every pulled-up line rose out of reset, so the first read sees all
        rd_chk("status flush", 8'h4C, 32'hFFFF_FFFF);
        wr_reg(8'h40, 32'h0000_0300);
        rd_chk("irq armed", 8'h48, 32'h0000_0300);
        wr_reg(8'h44, 32'h0000_0200);
        rd_chk("irq mask", 8'h48, 32'h0000_0100);
        @(posedge clk);
        ext_val <= ext_val ^ 32'h0000_0300;
        repeat (8) @(posedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd_chk("change status", 8'h4C, 32'h0000_0300);
        rd_chk("change status cleared", 8'h4C, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("irq dropped", 32'h0, {31'h0, irq});
        wr_reg(8'h44, 32'h0000_0100);
        ext_val <= ext_val ^ 32'h0000_0100;
        repeat (8) @(posedge clk);
        chk("irq disarmed", 32'h0, {31'h0, irq});
        rd_chk("unmasked change", 8'h4C, 32'h0000_0100);
        $display("test change done");
        @(posedge clk);
        ext_val[10] <= 1'b1;
        @(posedge clk);
        ext_val[10] <= 1'b0;
        repeat (10) @(posedge clk);
        rd_chk("glitch dropped", 8'h4C, 32'h0000_0000);
        wr_reg(8'h24, 32'h0000_0400);
        @(posedge clk);
        ext_val[10] <= 1'b1;
        @(posedge clk);
        ext_val[10] <= 1'b0;
        repeat (10) @(posedge clk);
        rd_chk("glitch seen", 8'h4C, 32'h0000_0400);
        wr_reg(8'h14, 32'h0000_00F0);
        rd_chk("output disabled", 8'h18, 32'h0000_000F);
        $display("test filter done");
        wrap_up();
    end
endmodule : plc_line_control_tb
